// file: rtl/sswc_device.sv
// Device end: sync/strobe control and capture window registers.
// Assumes the host keeps window values in range; no checks here.
//
// Behaviour
// - Sync request gives one-cycle frame trigger
// - Sync always holds trigger high; reset set
// - External enable lets trigger pin drive trigger
// - Auto strobe only in single-frame shutter mode
// - Auto strobe rises when all rows integrate
// - Width one: high until row before readout
// - Width zero: high exactly one row time
// - Force bit holds strobe high until cleared
// - Force overrides auto enable and width
// - One frame output per trigger, single-frame
// - Window: eleven-bit row/column origin and extent
// - Software keeps origins within row/column limits
// - Software keeps extents within row/column limits
// - No window checking; software ensures validity
// - Row origin split high/low, resets to 16
// - Row extent from two registers; rows plus one
`timescale 1ns/1ps
module sswc_device #(
    parameter int ROW_CYCLES = sswc_pkg::ROW_TIME_CYCLES
) (
    input  wire logic  mclk,
    input  wire logic  srst,
    sswc_if.device     bus,
    input  wire logic  all_integ,
    input  wire logic  readout_near,
    input  wire logic  frame_done,
    output logic       frame_trigger,
    output logic       strobe_pin,
    output logic       frame_start,
    output logic [10:0] row_origin,
    output logic [10:0] row_extent,
    output logic [10:0] col_origin,
    output logic [10:0] col_extent,
    output logic [11:0] row_count
);
    logic [7:0]  ctrl_reg;       // Sync/strobe control
    logic [7:0]  ctrl_next;
    logic [7:0]  mode_reg;       // Capture mode (bit 6 single frame)
    logic [7:0]  mode_next;
    logic [10:0] row_org_reg;    // Window row origin
    logic [10:0] row_org_next;
    logic [10:0] row_ext_reg;    // Window row extent
    logic [10:0] row_ext_next;
    logic [10:0] col_org_reg;    // Window column origin
    logic [10:0] col_org_next;
    logic [10:0] col_ext_reg;    // Window column extent
    logic [10:0] col_ext_next;
    logic        req_reg;        // Pending one-cycle sync request
    logic        req_next;
    logic        trig_reg;       // Frame trigger
    logic        trig_next;
    logic        strobe_reg;     // Strobe pin
    logic        strobe_next;
    logic        busy_reg;       // Single-frame in progress
    logic        busy_next;
    logic        start_reg;      // Frame start pulse
    logic        start_next;
    logic [7:0]  rdata_reg;      // Read data
    logic [7:0]  rdata_next;
    logic        auto_strobe;    // From strobe timer
    logic        single_frame;   // Single-frame shutter selected
    logic        trig_prev_reg;  // Trigger of last cycle
    logic        trig_prev_next;
    logic [11:0] row_cnt_reg;    // Rows captured, extent plus one
    logic [11:0] row_cnt_next;

    assign single_frame = mode_reg[sswc_pkg::BIT_SINGLE_FRAME];

    // Automatic strobe timer, enabled only in single-frame mode
    sswc_strobe_timer #(
        .ROW_CYCLES (ROW_CYCLES)
    ) u_timer (
        .mclk         (mclk),
        .srst         (srst),
        .enable       (ctrl_reg[sswc_pkg::BIT_STROBE_AUTO] & single_frame),
        .width_max    (ctrl_reg[sswc_pkg::BIT_STROBE_WIDTH]),
        .all_integ    (all_integ),
        .readout_near (readout_near),
        .strobe       (auto_strobe)
    );

    // Register writes and reads
    always_comb begin
        ctrl_next    = ctrl_reg;
        mode_next    = mode_reg;
        row_org_next = row_org_reg;
        row_ext_next = row_ext_reg;
        col_org_next = col_org_reg;
        col_ext_next = col_ext_reg;
        req_next     = 1'b0;
        rdata_next   = 8'h00;
        // Request bit never stored
        ctrl_next[sswc_pkg::BIT_SYNC_REQUEST] = 1'b0;
        if (bus.wr_stb) begin
            // No range check on window values
            if (bus.addr == sswc_pkg::ADDR_SYNC_FLASH_CONTROL) begin
                ctrl_next = {2'b00, bus.wdata[5:1], 1'b0};
                req_next  = bus.wdata[sswc_pkg::BIT_SYNC_REQUEST];
            end else if (bus.addr == sswc_pkg::ADDR_CAPTURE_MODE) begin
                mode_next = bus.wdata;
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_ORIGIN_HIGH) begin
                row_org_next[10:8] = bus.wdata[2:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_ORIGIN_LOW) begin
                row_org_next[7:0] = bus.wdata;
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_EXTENT_HIGH) begin
                row_ext_next[10:8] = bus.wdata[2:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_EXTENT_LOW) begin
                row_ext_next[7:0] = bus.wdata;
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_ORIGIN_HIGH) begin
                col_org_next[10:8] = bus.wdata[2:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_ORIGIN_LOW) begin
                col_org_next[7:0] = bus.wdata;
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_EXTENT_HIGH) begin
                col_ext_next[10:8] = bus.wdata[2:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_EXTENT_LOW) begin
                col_ext_next[7:0] = bus.wdata;
            end
        end
        if (bus.rd_stb) begin
            // Unused control and window bits and unmapped offsets read zero
            if (bus.addr == sswc_pkg::ADDR_SYNC_FLASH_CONTROL) begin
                rdata_next = {2'b00, ctrl_reg[5:1], 1'b0};
            end else if (bus.addr == sswc_pkg::ADDR_CAPTURE_MODE) begin
                rdata_next = mode_reg;
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_ORIGIN_HIGH) begin
                rdata_next = {5'b00000, row_org_reg[10:8]};
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_ORIGIN_LOW) begin
                rdata_next = row_org_reg[7:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_EXTENT_HIGH) begin
                rdata_next = {5'b00000, row_ext_reg[10:8]};
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_ROW_EXTENT_LOW) begin
                rdata_next = row_ext_reg[7:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_ORIGIN_HIGH) begin
                rdata_next = {5'b00000, col_org_reg[10:8]};
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_ORIGIN_LOW) begin
                rdata_next = col_org_reg[7:0];
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_EXTENT_HIGH) begin
                rdata_next = {5'b00000, col_ext_reg[10:8]};
            end else if (bus.addr == sswc_pkg::ADDR_WINDOW_COL_EXTENT_LOW) begin
                rdata_next = col_ext_reg[7:0];
            end
        end
        // Registered row count keeps the output glitch free
        row_cnt_next = {1'b0, row_ext_next} + 12'h001;
    end

    // Trigger, strobe and frame sequencing
    always_comb begin
        trig_next      = 1'b0;
        strobe_next    = 1'b0;
        busy_next      = busy_reg;
        start_next     = 1'b0;
        trig_prev_next = trig_reg;
        if (ctrl_reg[sswc_pkg::BIT_SYNC_ALWAYS]) begin
            trig_next = 1'b1;
        end else if (req_reg) begin
            trig_next = 1'b1;
        end else if (ctrl_reg[sswc_pkg::BIT_EXT_TRIG_EN] && bus.trig_pin) begin
            trig_next = 1'b1;
        end
        // Force overrides the automatic settings
        if (ctrl_reg[sswc_pkg::BIT_STROBE_FORCE]) begin
            strobe_next = 1'b1;
        end else begin
            strobe_next = auto_strobe;
        end
        // Single frame: one rising trigger gives one frame
        if (single_frame) begin
            // A new trigger edge beats the end of the previous frame
            if (trig_reg && !trig_prev_reg && (!busy_reg || frame_done)) begin
                busy_next  = 1'b1;
                start_next = 1'b1;
            end else if (busy_reg && frame_done) begin
                busy_next = 1'b0;
            end
        end else begin
            busy_next  = 1'b0;
            start_next = trig_reg && !busy_reg && frame_done;
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg      <= sswc_pkg::RST_SYNC_FLASH_CONTROL;
            mode_reg      <= sswc_pkg::RST_CAPTURE_MODE;
            row_org_reg   <= sswc_pkg::RST_ROW_ORIGIN;
            row_ext_reg   <= sswc_pkg::RST_ROW_EXTENT;
            col_org_reg   <= sswc_pkg::RST_COL_ORIGIN;
            col_ext_reg   <= sswc_pkg::RST_COL_EXTENT;
            req_reg       <= 1'b0;
            trig_reg      <= 1'b0;
            strobe_reg    <= 1'b0;
            busy_reg      <= 1'b0;
            start_reg     <= 1'b0;
            rdata_reg     <= 8'h00;
            trig_prev_reg <= 1'b0;
            row_cnt_reg   <= {1'b0, sswc_pkg::RST_ROW_EXTENT} + 12'h001;
        end else begin
            ctrl_reg      <= ctrl_next;
            mode_reg      <= mode_next;
            row_org_reg   <= row_org_next;
            row_ext_reg   <= row_ext_next;
            col_org_reg   <= col_org_next;
            col_ext_reg   <= col_ext_next;
            req_reg       <= req_next;
            trig_reg      <= trig_next;
            strobe_reg    <= strobe_next;
            busy_reg      <= busy_next;
            start_reg     <= start_next;
            rdata_reg     <= rdata_next;
            trig_prev_reg <= trig_prev_next;
            row_cnt_reg   <= row_cnt_next;
        end
    end

    assign bus.rdata     = rdata_reg;
    assign frame_trigger = trig_reg;
    assign strobe_pin    = strobe_reg;
    assign frame_start   = start_reg;
    assign row_origin    = row_org_reg;
    assign row_extent    = row_ext_reg;
    assign col_origin    = col_org_reg;
    assign col_extent    = col_ext_reg;
    // Rows captured is extent plus one
    assign row_count     = row_cnt_reg;
endmodule

// file: rtl/sswc_host.sv
// Host end: forwards software commands to device registers and trigger pin.
// Assumes software keeps window values within the legal limits.
`timescale 1ns/1ps
module sswc_host (
    input  wire logic  mclk,
    input  wire logic  srst,
    sswc_if.host       dev,
    input  wire logic [3:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output logic [7:0]      sw_rdata
);
    typedef enum logic [1:0] {H_IDLE, H_WRITE, H_READ, H_WAIT} sswc_hstate_t;
    sswc_hstate_t st_reg, st_next;  // Command state
    logic [7:0] dreg_reg, dreg_next;   // Device offset to access
    logic [7:0] wd_reg, wd_next;       // Write data staged
    logic [7:0] rd_reg, rd_next;       // Last device read value
    logic       busy;                  // Command in flight
    logic       pin_reg, pin_next;     // Trigger pin level
    logic       wr_reg, wr_next;       // Bus write strobe
    logic       rds_reg, rds_next;     // Bus read strobe
    logic [7:0] swr_reg, swr_next;     // Software read data

    assign busy = (st_reg != H_IDLE);

    // Command sequencing and software register file
    always_comb begin
        st_next   = st_reg;
        dreg_next = dreg_reg;
        wd_next   = wd_reg;
        rd_next   = rd_reg;
        pin_next  = pin_reg;
        wr_next   = 1'b0;
        rds_next  = 1'b0;
        swr_next  = 8'h00;
        case (st_reg)
            H_WRITE: begin
                st_next = H_IDLE;
            end
            H_READ: begin
                st_next = H_WAIT;
            end
            H_WAIT: begin
                rd_next = dev.rdata;
                st_next = H_IDLE;
            end
            default: begin
            end
        endcase
        if (sw_wr) begin
            // Software keeps window values in range
            if (sw_addr == sswc_pkg::HOST_ADDR_CMD && !busy) begin
                dreg_next = sw_wdata;
                if (sw_wdata[7]) begin
                    // Top bit flags a read; offset in low bits
                    dreg_next = {1'b0, sw_wdata[6:0]};
                    rds_next  = 1'b1;
                    st_next   = H_READ;
                end else begin
                    wr_next = 1'b1;
                    st_next = H_WRITE;
                end
            end else if (sw_addr == sswc_pkg::HOST_ADDR_WDATA) begin
                wd_next = sw_wdata;
            end else if (sw_addr == sswc_pkg::HOST_ADDR_PIN) begin
                pin_next = sw_wdata[0];
            end
        end
        if (sw_rd) begin
            if (sw_addr == sswc_pkg::HOST_ADDR_STATUS) begin
                swr_next = {7'h00, busy};
            end else if (sw_addr == sswc_pkg::HOST_ADDR_RDATA) begin
                swr_next = rd_reg;
            end else if (sw_addr == sswc_pkg::HOST_ADDR_PIN) begin
                swr_next = {7'h00, pin_reg};
            end
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg   <= H_IDLE;
            dreg_reg <= 8'h00;
            wd_reg   <= 8'h00;
            rd_reg   <= 8'h00;
            pin_reg  <= 1'b0;
            wr_reg   <= 1'b0;
            rds_reg  <= 1'b0;
            swr_reg  <= 8'h00;
        end else begin
            st_reg   <= st_next;
            dreg_reg <= dreg_next;
            wd_reg   <= wd_next;
            rd_reg   <= rd_next;
            pin_reg  <= pin_next;
            wr_reg   <= wr_next;
            rds_reg  <= rds_next;
            swr_reg  <= swr_next;
        end
    end

    assign dev.wr_stb   = wr_reg;
    assign dev.rd_stb   = rds_reg;
    assign dev.addr     = dreg_reg;
    assign dev.wdata    = wd_reg;
    assign dev.trig_pin = pin_reg;
    assign sw_rdata     = swr_reg;
endmodule

// file: rtl/sswc_if.sv
// Interface joining the host controller and the sync/strobe device end.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface sswc_if;
    logic       wr_stb;     // Register write strobe
    logic       rd_stb;     // Register read strobe
    logic [7:0] addr;       // Register offset
    logic [7:0] wdata;      // Write data
    logic [7:0] rdata;      // Read data, one cycle after rd_stb
    logic       trig_pin;   // External frame trigger pin

    // Device end
    modport device (
        input  wr_stb,
        input  rd_stb,
        input  addr,
        input  wdata,
        output rdata,
        input  trig_pin
    );
    // Host end
    modport host (
        output wr_stb,
        output rd_stb,
        output addr,
        output wdata,
        input  rdata,
        output trig_pin
    );
endinterface

// file: rtl/sswc_pkg.sv
// Shared constants for the sync, strobe and capture window block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package sswc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SYNC_FLASH_CONTROL     = 8'h42;
    localparam logic [7:0] ADDR_CAPTURE_MODE           = 8'h40;
    localparam logic [7:0] ADDR_WINDOW_ROW_ORIGIN_HIGH = 8'h45;
    localparam logic [7:0] ADDR_WINDOW_ROW_ORIGIN_LOW  = 8'h46;
    localparam logic [7:0] ADDR_WINDOW_ROW_EXTENT_HIGH = 8'h47;
    localparam logic [7:0] ADDR_WINDOW_ROW_EXTENT_LOW  = 8'h48;
    localparam logic [7:0] ADDR_WINDOW_COL_ORIGIN_HIGH = 8'h49;
    localparam logic [7:0] ADDR_WINDOW_COL_ORIGIN_LOW  = 8'h4A;
    localparam logic [7:0] ADDR_WINDOW_COL_EXTENT_HIGH = 8'h4B;
    localparam logic [7:0] ADDR_WINDOW_COL_EXTENT_LOW  = 8'h4C;
    // Field positions in the sync and strobe control register; single frame is bit 6 of capture mode
    localparam int BIT_SYNC_REQUEST  = 0;
    localparam int BIT_SYNC_ALWAYS   = 1;
    localparam int BIT_EXT_TRIG_EN   = 2;
    localparam int BIT_STROBE_AUTO   = 3;
    localparam int BIT_STROBE_WIDTH  = 4;
    localparam int BIT_STROBE_FORCE  = 5;
    localparam int BIT_SINGLE_FRAME  = 6;
    // Reset values
    localparam logic [7:0]  RST_SYNC_FLASH_CONTROL = 8'h02;
    localparam logic [7:0]  RST_CAPTURE_MODE       = 8'h00;
    localparam logic [10:0] RST_ROW_ORIGIN         = 11'h010;
    localparam logic [10:0] RST_ROW_EXTENT         = 11'h3FF;
    localparam logic [10:0] RST_COL_ORIGIN         = 11'h008;
    localparam logic [10:0] RST_COL_EXTENT         = 11'h4FF;
    // Legal window limits for software
    localparam logic [10:0] MAX_ROW = 11'h417;
    localparam logic [10:0] MAX_COL = 11'h50F;
    // Host command port offsets
    localparam logic [3:0] HOST_ADDR_CMD    = 4'h0;
    localparam logic [3:0] HOST_ADDR_WDATA  = 4'h1;
    localparam logic [3:0] HOST_ADDR_STATUS = 4'h2;
    localparam logic [3:0] HOST_ADDR_RDATA  = 4'h3;
    localparam logic [3:0] HOST_ADDR_PIN    = 4'h4;
    // Default row time in cycles
    localparam int ROW_TIME_CYCLES = 16;
endpackage

// file: rtl/sswc_strobe_timer.sv
// Automatic strobe timer: times strobe against all-rows-integrating.
// Assumes all_integ and readout_near are one-cycle pulses from a sequencer.
`timescale 1ns/1ps
module sswc_strobe_timer #(
    parameter int ROW_CYCLES = sswc_pkg::ROW_TIME_CYCLES
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic enable,
    input  wire logic width_max,
    input  wire logic all_integ,
    input  wire logic readout_near,
    output logic      strobe
);
    logic        strobe_reg;   // Automatic strobe level
    logic        strobe_next;
    logic [15:0] cnt_reg;      // Row-time down counter
    logic [15:0] cnt_next;

    // Next-state of strobe and row counter
    always_comb begin
        strobe_next = strobe_reg;
        cnt_next    = cnt_reg;
        if (!enable) begin
            strobe_next = 1'b0;
            cnt_next    = 16'h0000;
        end else if (all_integ) begin
            strobe_next = 1'b1;
            cnt_next    = 16'(ROW_CYCLES - 1);
        end else if (strobe_reg) begin
            if (width_max) begin
                // Ends one row before first readout
                if (readout_near) begin
                    strobe_next = 1'b0;
                end
            end else if (cnt_reg == 16'h0000) begin
                strobe_next = 1'b0;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            strobe_reg <= 1'b0;
            cnt_reg    <= 16'h0000;
        end else begin
            strobe_reg <= strobe_next;
            cnt_reg    <= cnt_next;
        end
    end

    assign strobe = strobe_reg;
endmodule

// file: test/sswc_checker.sv
// Checker on the host/device interface and the device's trigger and strobe pins.
// Assumes one clock, synchronous active-high reset, instantiated in tb_top.
`timescale 1ns/1ps
module sswc_checker #(
    parameter int ROW_CYCLES = sswc_pkg::ROW_TIME_CYCLES
) (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       trig_pin,
    input wire logic       all_integ,
    input wire logic       readout_near,
    input wire logic       frame_trigger,
    input wire logic       strobe_pin
);
    logic [5:1]  ctl_reg, ctl_next;   // Shadow of control bits 5..1
    logic        mode_reg, mode_next; // Shadow of single-frame mode bit
    logic [15:0] run_reg, run_next;   // Length of current strobe high run
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Next shadow values from observed register writes
    always_comb begin
        ctl_next = ctl_reg;
        mode_next = mode_reg;
        if (wr_stb && addr == sswc_pkg::ADDR_SYNC_FLASH_CONTROL) begin
            ctl_next = wdata[5:1];
        end
        if (wr_stb && addr == sswc_pkg::ADDR_CAPTURE_MODE) begin
            mode_next = wdata[6];
        end
        run_next = strobe_pin ? run_reg + 16'h0001 : 16'h0000;
    end
    // Register the shadows
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_reg <= sswc_pkg::RST_SYNC_FLASH_CONTROL[5:1];
            mode_reg <= 1'b0;
            run_reg <= 16'h0000;
        end else begin
            ctl_reg <= ctl_next;
            mode_reg <= mode_next;
            run_reg <= run_next;
        end
    end
    // Trigger high for one cycle, then low
    sequence one_pulse;
        frame_trigger ##1 !frame_trigger;
    endsequence
    sequence req_write;
        wr_stb && addr == sswc_pkg::ADDR_SYNC_FLASH_CONTROL && wdata[2:0] == 3'h1;
    endsequence
    request_pulse_a: assert property (req_write |-> ##2 one_pulse)
        else $error("sync request did not give a one-cycle trigger");
    request_reads_zero_a: assert property (
        rd_stb && addr == sswc_pkg::ADDR_SYNC_FLASH_CONTROL |=> rdata[0] == 1'b0)
        else $error("sync request bit read back as one");
    always_trigger_a: assert property (ctl_reg[1] |=> frame_trigger)
        else $error("trigger low while sync always set");
    pin_follow_a: assert property (
        $past(ctl_reg[2]) && !$past(ctl_reg[1]) && !$past(wr_stb, 2)
        |-> frame_trigger == $past(trig_pin))
        else $error("trigger does not follow the pin");
    auto_rise_a: assert property (
        all_integ && ctl_reg[3] && mode_reg && !ctl_reg[5] && !strobe_pin |-> ##2 strobe_pin)
        else $error("auto strobe did not rise");
    wide_fall_a: assert property (
        readout_near && ctl_reg[3] && ctl_reg[4] && mode_reg && !ctl_reg[5] |-> ##2 !strobe_pin)
        else $error("wide strobe did not fall before readout");
    row_width_a: assert property (
        $fell(strobe_pin) && ctl_reg[3] && !ctl_reg[4] && !ctl_reg[5] && mode_reg
        |-> run_reg == 16'(ROW_CYCLES))
        else $error("narrow strobe not one row long");
    force_high_a: assert property (ctl_reg[5] |=> strobe_pin)
        else $error("forced strobe not high");
endmodule

// file: test/tb_top.sv
// Testbench: host and device ends joined by the interface, driven from software side.
// Assumes a short row time parameter of four cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int ROW = 4;          // Shortened row time
    logic mclk, srst;                // Clock and reset
    logic [3:0] sw_addr;             // Software port
    logic [7:0] sw_wdata, sw_rdata, rd;
    logic sw_wr, sw_rd, all_integ, readout_near, frame_done;
    logic frame_trigger, strobe_pin, frame_start;
    logic [10:0] row_origin, row_extent, col_origin, col_extent;
    logic [11:0] row_count, k;
    int mismatches = 0, checks = 0, cyc = 0;
    sswc_if bus_if ();
    sswc_device #(.ROW_CYCLES(ROW)) sswc_device_inst (.mclk(mclk), .srst(srst), .bus(bus_if),
        .all_integ(all_integ), .readout_near(readout_near), .frame_done(frame_done),
        .frame_trigger(frame_trigger), .strobe_pin(strobe_pin), .frame_start(frame_start),
        .row_origin(row_origin), .row_extent(row_extent), .col_origin(col_origin),
        .col_extent(col_extent), .row_count(row_count));
    sswc_host sswc_host_inst (.mclk(mclk), .srst(srst), .dev(bus_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    sswc_checker #(.ROW_CYCLES(ROW)) sswc_checker_inst (.mclk(mclk), .srst(srst),
        .wr_stb(bus_if.wr_stb), .rd_stb(bus_if.rd_stb), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata), .trig_pin(bus_if.trig_pin),
        .all_integ(all_integ), .readout_near(readout_near),
        .frame_trigger(frame_trigger), .strobe_pin(strobe_pin));
    // Clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task sw_w(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask
    // Device register write and read through host commands
    task dev_w(input logic [7:0] off, input logic [7:0] d);
        sw_w(4'h1, d);
        sw_w(4'h0, off);
    endtask
    task dev_r(input logic [7:0] off, output logic [7:0] d);
        sw_w(4'h0, 8'h80 | off);
        repeat (5) @(posedge mclk);
        sw_addr <= 4'h3;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task pulse(input int sel);
        @(posedge mclk);
        all_integ <= (sel == 0);
        readout_near <= (sel == 1);
        frame_done <= (sel == 2);
        @(posedge mclk);
        all_integ <= 1'b0;
        readout_near <= 1'b0;
        frame_done <= 1'b0;
    endtask
    // Count high cycles of trigger, strobe or frame start
    task cnt(input int sel, input int n, output logic [11:0] c);
        c = 12'h000;
        repeat (n) begin
            @(posedge mclk);
            #1;
            c += {11'h000, (sel == 0 ? frame_trigger : sel == 1 ? strobe_pin : frame_start) === 1'b1};
        end
    endtask
    task end_of_test();
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
        {all_integ, readout_near, frame_done} = 3'h0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        settle(2);
        chk(frame_trigger, 1'b1);
        dev_r(8'h42, rd);
        chk(rd, 8'h02);
        dev_r(8'h46, rd);
        chk(rd, 8'h10);
        chk(row_origin, 11'h010);
        chk(row_count, 12'h400);
        dev_w(8'h45, 8'h04);
        dev_w(8'h46, 8'h17);
        dev_w(8'h47, 8'h04);
        dev_w(8'h48, 8'h17);
        dev_w(8'h49, 8'h05);
        dev_w(8'h4A, 8'h0F);
        dev_w(8'h4B, 8'h05);
        dev_w(8'h4C, 8'h0F);
        settle(4);
        chk(col_extent, 11'h50F);
        chk(row_origin, 11'h417);
        chk(row_extent, 11'h417);
        chk(row_count, 12'h418);
        chk(col_origin, 11'h50F);
        dev_w(8'h42, 8'h00);
        settle(4);
        cnt(0, 10, k);
        chk(k, 12'h000);
        dev_w(8'h42, 8'h01);
        cnt(0, 10, k);
        chk(k, 12'h001);
        dev_r(8'h42, rd);
        chk(rd, 8'h00);
        dev_w(8'h42, 8'h04);
        sw_w(4'h4, 8'h01);
        settle(4);
        chk(frame_trigger, 1'b1);
        sw_w(4'h4, 8'h00);
        settle(4);
        chk(frame_trigger, 1'b0);
        dev_w(8'h42, 8'h08);
        settle(4);
        pulse(0);
        cnt(1, 10, k);
        chk(k, 12'h000);
        dev_w(8'h40, 8'h40);
        dev_w(8'h42, 8'h28);
        settle(4);
        pulse(0);
        settle(8);
        chk(strobe_pin, 1'b1);
        dev_w(8'h42, 8'h00);
        settle(4);
        chk(strobe_pin, 1'b0);
        dev_w(8'h42, 8'h08);
        settle(4);
        pulse(0);
        cnt(1, 12, k);
        chk(k, 12'(ROW));
        dev_w(8'h42, 8'h18);
        settle(4);
        pulse(0);
        settle(8);
        chk(strobe_pin, 1'b1);
        pulse(1);
        settle(3);
        chk(strobe_pin, 1'b0);
        dev_w(8'h42, 8'h00);
        pulse(2);
        dev_w(8'h42, 8'h01);
        cnt(2, 10, k);
        chk(k, 12'h001);
        dev_w(8'h42, 8'h01);
        cnt(2, 10, k);
        chk(k, 12'h000);
        pulse(2);
        dev_w(8'h42, 8'h01);
        cnt(2, 10, k);
        chk(k, 12'h001);
        dev_r(8'h50, rd);
        chk(rd, 8'h00);
        end_of_test();
    end
endmodule
